// ---- rtl/pmpc_mode_protect.sv ----
// Mode permission and run mode control registers behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "pmpc_map.svh"

module pmpc_mode_protect (
    // Clock and resets
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic chipRstn,
    input wire logic sysRstn,
    // Register bus
    input wire pmpc_pkg::pmpc_axil_req_t axiReq,
    output wire pmpc_pkg::pmpc_axil_rsp_t axiRsp,
    // Mode controller side
    input wire logic exitToRun,
    output wire pmpc_pkg::pmpc_allow_t allow,
    output logic lowPowerRun
);
    import pmpc_pkg::*;

    // Reset scopes: power-on covers chip, chip covers system
    wire porRst;
    wire chipRst;
    wire sysRst;
    assign porRst = !rstn;
    assign chipRst = porRst || !chipRstn;
    assign sysRst = chipRst || !sysRstn;

    // Bus state
    logic awHeld;
    logic wHeld;
    logic [31:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;

    // Register state
    logic permWritten;
    logic allow_very_low_power;
    logic allow_low_leakage_stop;
    logic allow_very_low_leakage_stop;
    pmpc_run_t runState;
    pmpc_run_t next_runState;
    // Reset image split per bit, so no shifted constant gets truncated
    wire [7:0] permRstVal;
    assign permRstVal = `PMPC_PERM_RST;

    // Channel handshakes
    wire awTake;
    wire wTake;
    wire arTake;
    wire doWrite;
    assign axiRsp.awready = !awHeld && !bValid;
    assign axiRsp.wready = !wHeld && !bValid;
    assign axiRsp.arready = !rValid;
    assign awTake = axiReq.awvalid && axiRsp.awready;
    assign wTake = axiReq.wvalid && axiRsp.wready;
    assign arTake = axiReq.arvalid && axiRsp.arready;
    // Write happens once both halves are held
    assign doWrite = awHeld && wHeld && !bValid;

    // Write decode
    wire wrHighZero;
    wire wrPermSel;
    wire wrCtrlSel;
    wire wrMapped;
    wire wrLane0;
    assign wrHighZero = (awAddr[31:10] == 22'h0) && (awAddr[1:0] == 2'h0);
    assign wrPermSel = wrHighZero && (awAddr[9:2] == `PMPC_IDX_PERM);
    assign wrCtrlSel = wrHighZero && (awAddr[9:2] == `PMPC_IDX_CTRL);
    assign wrMapped = wrPermSel || wrCtrlSel;
    // Only byte lane 0 carries the 8-bit registers
    assign wrLane0 = wStrb[0];

    // Read decode
    wire rdHighZero;
    wire rdPermSel;
    wire rdCtrlSel;
    wire rdMapped;
    assign rdHighZero = (axiReq.araddr[31:10] == 22'h0) && (axiReq.araddr[1:0] == 2'h0);
    assign rdPermSel = rdHighZero && (axiReq.araddr[9:2] == `PMPC_IDX_PERM);
    assign rdCtrlSel = rdHighZero && (axiReq.araddr[9:2] == `PMPC_IDX_CTRL);
    assign rdMapped = rdPermSel || rdCtrlSel;

    // Permission write acceptance
    wire permWrite;
    assign permWrite = doWrite && wrPermSel && wrLane0 && !permWritten;

    // Run select request decode
    wire ctrlWrite;
    wire [1:0] runmReq;
    wire reqNormal;
    wire reqLowPower;
    wire lowPowerOk;
    assign ctrlWrite = doWrite && wrCtrlSel && wrLane0;
    assign runmReq = wData[`PMPC_RUN_MODE_SELECT_HI:`PMPC_RUN_MODE_SELECT_LO];
    assign reqNormal = ctrlWrite && (runmReq == `PMPC_RUN_MODE_SELECT_NORMAL);
    assign reqLowPower = ctrlWrite && (runmReq == `PMPC_RUN_MODE_SELECT_LPR);
    // Codes 01 and 11 match neither request and are dropped
    assign lowPowerOk = reqLowPower && allow_very_low_power;

    // Read values
    wire [7:0] permReadVal;
    wire [1:0] runmRead;
    wire [7:0] ctrlReadVal;
    assign permReadVal = {2'h0, allow_very_low_power, 1'h0, allow_low_leakage_stop, 1'h0, allow_very_low_leakage_stop, 1'h0};
    assign runmRead = (runState == PMPC_RUN_LOW_POWER) ? `PMPC_RUN_MODE_SELECT_LPR : `PMPC_RUN_MODE_SELECT_NORMAL;
    // Bit 7 is not stored, so a stray one cannot reach any logic
    assign ctrlReadVal = {1'h0, runmRead, 5'h00};

    // Run mode sequencing
    always_comb begin
        next_runState = runState;
        case (runState)
            PMPC_RUN_NORMAL: begin
                if (lowPowerOk) begin
                    next_runState = PMPC_RUN_LOW_POWER;
                end
            end
            PMPC_RUN_LOW_POWER: begin
                // Hardware exit wins over a same-cycle software write
                if (exitToRun || reqNormal) begin
                    next_runState = PMPC_RUN_NORMAL;
                end
            end
            default: begin
                next_runState = PMPC_RUN_NORMAL;
            end
        endcase
    end

    // Address and data capture
    always_ff @(posedge ref_clk) begin
        if (sysRst) begin
            awHeld <= 1'h0;
            wHeld <= 1'h0;
            awAddr <= 32'h0;
            wData <= 32'h0;
            wStrb <= 4'h0;
        end else begin
            if (awTake) begin
                awHeld <= 1'h1;
                awAddr <= axiReq.awaddr;
            end else if (doWrite) begin
                awHeld <= 1'h0;
            end
            if (wTake) begin
                wHeld <= 1'h1;
                wData <= axiReq.wdata;
                wStrb <= axiReq.wstrb;
            end else if (doWrite) begin
                wHeld <= 1'h0;
            end
        end
    end

    // Write response
    always_ff @(posedge ref_clk) begin
        if (sysRst) begin
            bValid <= 1'h0;
            bResp <= `PMPC_RESP_OKAY;
        end else if (doWrite) begin
            bValid <= 1'h1;
            bResp <= wrMapped ? `PMPC_RESP_OKAY : `PMPC_RESP_DECERR;
        end else if (bValid && axiReq.bready) begin
            bValid <= 1'h0;
        end
    end

    // Read response
    always_ff @(posedge ref_clk) begin
        if (sysRst) begin
            rValid <= 1'h0;
            rData <= 32'h0;
            rResp <= `PMPC_RESP_OKAY;
        end else if (arTake) begin
            rValid <= 1'h1;
            rData <= {24'h0, rdPermSel ? permReadVal : (rdCtrlSel ? ctrlReadVal : 8'h00)};
            rResp <= rdMapped ? `PMPC_RESP_OKAY : `PMPC_RESP_DECERR;
        end else if (rValid && axiReq.rready) begin
            rValid <= 1'h0;
        end
    end

    assign axiRsp.bvalid = bValid;
    assign axiRsp.bresp = bResp;
    assign axiRsp.rvalid = rValid;
    assign axiRsp.rdata = rData;
    assign axiRsp.rresp = rResp;

    // Write-once lock, reopened by any system reset
    always_ff @(posedge ref_clk) begin
        if (sysRst) begin
            permWritten <= 1'h0;
        end else if (permWrite) begin
            permWritten <= 1'h1;
        end
    end

    // Allow bits survive resets below chip level
    always_ff @(posedge ref_clk) begin
        if (chipRst) begin
            allow_very_low_power <= permRstVal[`PMPC_BIT_VLP];
            allow_low_leakage_stop <= permRstVal[`PMPC_BIT_LLS];
            allow_very_low_leakage_stop <= permRstVal[`PMPC_BIT_VLLS];
        end else if (permWrite) begin
            allow_very_low_power <= wData[`PMPC_BIT_VLP];
            allow_low_leakage_stop <= wData[`PMPC_BIT_LLS];
            allow_very_low_leakage_stop <= wData[`PMPC_BIT_VLLS];
        end
    end

    // Run mode survives resets below power-on
    always_ff @(posedge ref_clk) begin
        if (porRst) begin
            runState <= PMPC_RUN_NORMAL;
        end else begin
            runState <= next_runState;
        end
    end

    // Permissions to the mode controller
    assign allow.allowVlp = allow_very_low_power;
    assign allow.allowLls = allow_low_leakage_stop;
    assign allow.allowVlls = allow_very_low_leakage_stop;
    assign lowPowerRun = (runState == PMPC_RUN_LOW_POWER);

    // Checks
    a_perm_locked: assert property (@(posedge ref_clk) disable iff (!rstn)
        (permWritten && !chipRst) |=> $stable(permReadVal))
        else $error("Permission changed after the first write");

    a_first_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        (doWrite && wrPermSel && wrLane0 && !permWritten && !sysRst)
        |=> permWritten && (allow_very_low_power == $past(wData[5])) && (allow_very_low_leakage_stop == $past(wData[1])))
        else $error("First permission write not stored");

    a_chip_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
        chipRst |=> (permReadVal == 8'h00) && !permWritten)
        else $error("Chip reset left permission set");

    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rValid && $past(arTake) && $past(rdPermSel)) |-> ((rData & 32'hFFFF_FFD5) == 32'h0))
        else $error("Reserved permission bits read nonzero");

    a_block_lpr: assert property (@(posedge ref_clk) disable iff (!rstn)
        (reqLowPower && !allow_very_low_power && runState == PMPC_RUN_NORMAL)
        |=> (runmRead == 2'h0) && !lowPowerRun)
        else $error("Forbidden low-power run entered");

    a_enter_lpr: assert property (@(posedge ref_clk) disable iff (!rstn)
        (reqLowPower && allow_very_low_power && runState == PMPC_RUN_NORMAL)
        |=> lowPowerRun && (runmRead == 2'h2))
        else $error("Permitted low-power run not entered");

    a_reserved_code: assert property (@(posedge ref_clk) disable iff (!rstn)
        (ctrlWrite && wData[5] && !exitToRun) |=> $stable(runState))
        else $error("Reserved run code changed the mode");

    a_exit_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        (lowPowerRun && exitToRun) |=> (runmRead == 2'h0) && !lowPowerRun)
        else $error("Run select not cleared on exit");

    a_ctrl_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
        (chipRst && !ctrlWrite && !exitToRun) |=> $stable(runState))
        else $error("Chip reset disturbed run mode");

    a_write_answer: assert property (@(posedge ref_clk) disable iff (!rstn)
        (doWrite && !sysRst) |=> bValid ##0 (bResp == (($past(wrMapped)) ? 2'h0 : 2'h3)))
        else $error("Write answer missing or wrong");

    a_lock_reopen: assert property (@(posedge ref_clk) disable iff (!rstn)
        sysRst |=> !permWritten)
        else $error("Lock not reopened by system reset");

    a_sys_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sysRst && !chipRst && !permWrite) |=> $stable(permReadVal))
        else $error("System reset disturbed permission");

    a_lls_store: assert property (@(posedge ref_clk) disable iff (!rstn)
        (permWrite && !chipRst) |=> (allow_low_leakage_stop == $past(wData[`PMPC_BIT_LLS])))
        else $error("Leakage stop allow not stored");

    a_vlp_entry: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(lowPowerRun) |-> $past(allow_very_low_power))
        else $error("Low-power run entered without allow");

    a_normal_exit: assert property (@(posedge ref_clk) disable iff (!rstn)
        (lowPowerRun && reqNormal) |=> !lowPowerRun && (runmRead == 2'h0))
        else $error("Software return to normal run ignored");

    a_ctrl_fields: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rValid && $past(arTake) && $past(rdCtrlSel)) |-> ((rData & 32'hFFFF_FF9F) == 32'h0)
        && (rData[6:5] != 2'h1) && (rData[6:5] != 2'h3))
        else $error("Control readback holds a reserved value");

    a_strobe_off: assert property (@(posedge ref_clk) disable iff (!rstn)
        (doWrite && wrPermSel && !wrLane0 && !sysRst) |=> $stable(permWritten) && $stable(permReadVal))
        else $error("Write without lane 0 used the lock");

    // Bus checks that span an edge skip cycles with a system reset, which drops every channel
    a_decerr_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
        (doWrite && !wrMapped && !sysRst && !exitToRun) |=> $stable(permReadVal) && $stable(runState))
        else $error("Unmapped write changed state");

    a_read_answer: assert property (@(posedge ref_clk) disable iff (!rstn)
        (arTake && !sysRst) |=> rValid && (rResp == ($past(rdMapped) ? 2'h0 : 2'h3)))
        else $error("Read answer missing or wrong");

    a_bresp_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        (bValid && !axiReq.bready && !sysRst) |=> bValid && $stable(bResp))
        else $error("Write answer dropped before taken");

    a_rdata_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rValid && !axiReq.rready && !sysRst) |=> rValid && $stable(rData) && $stable(rResp))
        else $error("Read answer dropped before taken");

    a_busy_refuse: assert property (@(posedge ref_clk) disable iff (!rstn)
        bValid |-> !axiRsp.awready && !axiRsp.wready)
        else $error("Write taken while answer pending");

    a_ar_refuse: assert property (@(posedge ref_clk) disable iff (!rstn)
        rValid |-> !axiRsp.arready)
        else $error("Read taken while answer pending");

endmodule

// ---- inc/pmpc_map.svh ----
// Register offsets, field positions and reset values of the mode protect block
`ifndef PMPC_MAP_SVH
`define PMPC_MAP_SVH

// Register indices; byte address is four times the index
`define PMPC_IDX_PERM 8'h00
`define PMPC_IDX_CTRL 8'h01

// Permission register fields
`define PMPC_BIT_VLP 5
`define PMPC_BIT_LLS 3
`define PMPC_BIT_VLLS 1
`define PMPC_PERM_RST 8'h00

// Control register fields
`define PMPC_RUN_MODE_SELECT_HI 6
`define PMPC_RUN_MODE_SELECT_LO 5
`define PMPC_RUN_MODE_SELECT_NORMAL 2'h0
`define PMPC_RUN_MODE_SELECT_LPR 2'h2
`define PMPC_CTRL_RST 8'h00

// Bus answers
`define PMPC_RESP_OKAY 2'h0
`define PMPC_RESP_DECERR 2'h3

`endif

// ---- inc/pmpc_pkg.sv ----
// Types shared by the mode protect block and its bench
package pmpc_pkg;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } pmpc_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pmpc_axil_rsp_t;

    typedef struct packed {
        logic allowVlp;
        logic allowLls;
        logic allowVlls;
    } pmpc_allow_t;

    typedef enum {
        PMPC_RUN_NORMAL,
        PMPC_RUN_LOW_POWER
    } pmpc_run_t;

endpackage

// ---- verif/tb.sv ----
// Self-checking bench for the mode protect block over its register bus
`timescale 1ns/1ps
`include "pmpc_map.svh"

module tb;
    import pmpc_pkg::*;
    localparam logic [31:0] A_PERM = {22'h0, `PMPC_IDX_PERM, 2'h0};
    localparam logic [31:0] A_CTRL = {22'h0, `PMPC_IDX_CTRL, 2'h0};
    localparam logic [31:0] A_BAD = 32'h0000_0008;
    logic ref_clk = 1'b0;
    logic rstn;
    logic chipRstn;
    logic sysRstn;
    logic exitToRun;
    pmpc_axil_req_t req;
    pmpc_axil_rsp_t rsp;
    pmpc_allow_t allow;
    logic lowPowerRun;
    int errorCnt = 0;
    int nCompared = 0;
    logic [31:0] rv;
    logic [1:0] rs;
    logic [3:0] strb = 4'h1;

    always #5 ref_clk = ~ref_clk;

    pmpc_mode_protect uut (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .chipRstn(chipRstn),
        .sysRstn(sysRstn),
        .axiReq(req),
        .axiRsp(rsp),
        .exitToRun(exitToRun),
        .allow(allow),
        .lowPowerRun(lowPowerRun)
    );

    task automatic close_out();
        $display("compared %0d, errors %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge ref_clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= strb;
        req.bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            n++;
            if (n > 50) begin
                errorCnt++;
                close_out();
            end
        end while (rsp.bvalid !== 1'b1);
        resp = rsp.bresp;
        req.bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] data, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge ref_clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            n++;
            if (n > 50) begin
                errorCnt++;
                close_out();
            end
        end while (rsp.rvalid !== 1'b1);
        data = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
    endtask

    // One edge low on the chosen reset tiers: {power-on, chip, system}
    task automatic rst(input logic [2:0] m);
        @(posedge ref_clk);
        {rstn, chipRstn, sysRstn} <= ~m;
        @(posedge ref_clk);
        {rstn, chipRstn, sysRstn} <= 3'h7;
        @(posedge ref_clk);
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        rd(a, rv, rs);
        chk(rv, exp);
        chk({30'h0, rs}, {30'h0, `PMPC_RESP_OKAY});
    endtask

    initial begin
        {rstn, chipRstn, sysRstn} = 3'h0;
        exitToRun = 1'b0;
        req = '0;
        repeat (2) @(posedge ref_clk);
        {rstn, chipRstn, sysRstn} <= 3'h7;
        rchk(A_PERM, 32'h0000_0000);
        rchk(A_CTRL, 32'h0000_0000);
        // Low-power request before it is allowed must bounce
        wr(A_CTRL, 32'h0000_0040, rs);
        chk({30'h0, rs}, {30'h0, `PMPC_RESP_OKAY});
        rchk(A_CTRL, 32'h0000_0000);
        chk({31'h0, lowPowerRun}, 32'h0000_0000);
        wr(A_PERM, 32'h0000_00FF, rs);
        rchk(A_PERM, 32'h0000_002A);
        chk({29'h0, allow}, 32'h0000_0007);
        // Second write is locked out
        wr(A_PERM, 32'h0000_0000, rs);
        rchk(A_PERM, 32'h0000_002A);
        chk({29'h0, allow}, 32'h0000_0007);
        // Reserved run codes change nothing
        wr(A_CTRL, 32'h0000_0020, rs);
        rchk(A_CTRL, 32'h0000_0000);
        wr(A_CTRL, 32'h0000_0060, rs);
        rchk(A_CTRL, 32'h0000_0000);
        wr(A_CTRL, 32'h0000_0040, rs);
        chk({31'h0, lowPowerRun}, 32'h0000_0001);
        rchk(A_CTRL, 32'h0000_0040);
        // Hardware wake back to normal run
        @(posedge ref_clk);
        exitToRun <= 1'b1;
        @(posedge ref_clk);
        exitToRun <= 1'b0;
        @(posedge ref_clk);
        chk({31'h0, lowPowerRun}, 32'h0000_0000);
        rchk(A_CTRL, 32'h0000_0000);
        // Software round trip
        wr(A_CTRL, 32'h0000_0040, rs);
        chk({31'h0, lowPowerRun}, 32'h0000_0001);
        wr(A_CTRL, 32'h0000_0000, rs);
        @(posedge ref_clk);
        chk({31'h0, lowPowerRun}, 32'h0000_0000);
        // Unmapped place
        wr(A_BAD, 32'h0000_00FF, rs);
        chk({30'h0, rs}, {30'h0, `PMPC_RESP_DECERR});
        rd(A_BAD, rv, rs);
        chk({30'h0, rs}, {30'h0, `PMPC_RESP_DECERR});
        chk(rv, 32'h0000_0000);
        // System reset alone keeps state but reopens the lock
        wr(A_CTRL, 32'h0000_0040, rs);
        rst(3'h1);
        rchk(A_PERM, 32'h0000_002A);
        chk({31'h0, lowPowerRun}, 32'h0000_0001);
        // Write without lane 0 must not spend the one allowed write
        strb = 4'hE;
        wr(A_PERM, 32'h0000_00FF, rs);
        chk({30'h0, rs}, {30'h0, `PMPC_RESP_OKAY});
        rchk(A_PERM, 32'h0000_002A);
        strb = 4'h1;
        wr(A_PERM, 32'h0000_0008, rs);
        rchk(A_PERM, 32'h0000_0008);
        // Chip reset clears permission, not control
        rst(3'h3);
        rchk(A_PERM, 32'h0000_0000);
        rchk(A_CTRL, 32'h0000_0040);
        rst(3'h7);
        rchk(A_CTRL, 32'h0000_0000);
        chk({31'h0, lowPowerRun}, 32'h0000_0000);
        close_out();
    end
endmodule
